// File: hdl/blp_access_if.sv
// access request and permit signals between top and lock decoder
`timescale 1ns/1ps
interface blp_access_if;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    logic exec_boot;
    logic vec_boot;
    logic store_tgt_boot;
    logic load_tgt_boot;
    logic store_ok;
    logic load_ok;
    logic irq_block;
    modport req (output app_lock, boot_lock, exec_boot, vec_boot, store_tgt_boot,
                 load_tgt_boot, input store_ok, load_ok, irq_block);
    modport dec (input app_lock, boot_lock, exec_boot, vec_boot, store_tgt_boot,
                 load_tgt_boot, output store_ok, load_ok, irq_block);
endinterface : blp_access_if

// File: hdl/blp_arm_timer.sv
// store-enable arming window counter
`timescale 1ns/1ps
module blp_arm_timer (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // control
    input wire logic start,
    input wire logic consume,
    // status
    output logic open,
    output logic expire
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = blp_pkg::ARM_CYCLES;
        end else if (consume) begin
            cnt_d = 3'h0;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign open = (cnt_q != 3'h0);
    // last open cycle passing with no store and no fresh command closes the window
    assign expire = (cnt_q == 3'h1) && !consume && !start;
endmodule : blp_arm_timer

// File: hdl/blp_boot_lock.sv
// boot lock protection and self-programming control/status
`timescale 1ns/1ps
module blp_boot_lock #(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'hF000
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,

    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,

    // static configuration
    input wire logic [1:0] cfg_app_lock,
    input wire logic [1:0] cfg_boot_lock,
    input wire logic cfg_boot_reset_fuse,
    input wire logic cfg_vectors_in_boot,

    // external programmer
    input wire logic prog_lock_wr,
    input wire logic [3:0] prog_lock_data,
    input wire logic prog_chip_erase,

    // core program-memory store
    input wire logic core_exec_boot,
    input wire logic core_store,
    input wire logic core_store_tgt_boot,
    input wire logic core_store_tgt_rww,
    input wire logic [7:0] core_store_data,

    // core program-memory load
    input wire logic core_load,
    input wire logic core_load_tgt_boot,
    input wire logic core_load_tgt_rww,

    // core interrupt state
    input wire logic core_global_irq_en,

    // permits and vector back to the core
    output logic store_permit,
    output logic load_permit,
    output logic irq_mask,
    output logic store_ready_irq,
    output logic [15:0] reset_vector,

    // flash controller
    input wire logic flash_done,
    output logic op_page_erase,
    output logic op_page_write,
    output logic op_buffer_load,
    output logic op_lock_set,
    output logic op_reenable
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    // capture flag: low only until the first edge after reset
    logic loaded_q;

    // lock pairs {boot_hi, boot_lo, app_hi, app_lo} and boot reset fuse
    logic [3:0] lock_q;
    logic fuse_q;

    // control/status fields
    logic irq_en_q;
    logic busy_q;
    logic [4:0] cmd_q;
    // page erase or write handed to flash, waiting for done
    logic running_q;

    // read data and the two register views behind it
    logic [7:0] reg_rdata_q;
    logic [7:0] ctrl_view;
    logic [7:0] lock_view;

    // one-cycle operation strobes
    logic op_erase_q;
    logic op_write_q;
    logic op_load_q;
    logic op_lock_q;
    logic op_reen_q;

    // register port decode
    logic ctrl_wr;
    logic cmd_ok;

    // arming window
    logic arm_open;
    logic arm_expire;

    // store acceptance
    logic store_take;
    logic store_ok_raw;
    logic cmd_page;

    // operation starts, one per command except start_prog, which serves both page erase and page write
    logic start_prog;
    logic start_load;
    logic start_reen;
    logic start_lock;

    function automatic logic cmd_legal(input logic [4:0] c);
        cmd_legal = (c == blp_pkg::CMD_REENABLE) || (c == blp_pkg::CMD_LOCK_SET)
                  || (c == blp_pkg::CMD_PAGE_WRITE) || (c == blp_pkg::CMD_PAGE_ERASE)
                  || (c == blp_pkg::CMD_BUF_LOAD);
    endfunction : cmd_legal

    // erase and write are the only commands that touch a flash section
    function automatic logic cmd_is_page(input logic [4:0] c);
        cmd_is_page = (c == blp_pkg::CMD_PAGE_ERASE) || (c == blp_pkg::CMD_PAGE_WRITE);
    endfunction : cmd_is_page

    ////////////////////////////////////////////////////////////////////////////
    // lock decode
    // decoder is pure logic; every registered term stays in this module
    blp_access_if acc ();

    assign acc.app_lock = lock_q[blp_pkg::LOCK_APP_LO_BIT +: 2];
    assign acc.boot_lock = lock_q[blp_pkg::LOCK_BOOT_LO_BIT +: 2];
    assign acc.exec_boot = core_exec_boot;
    assign acc.vec_boot = cfg_vectors_in_boot;
    assign acc.store_tgt_boot = core_store_tgt_boot;
    assign acc.load_tgt_boot = core_load_tgt_boot;

    blp_lock_decode u_decode (
        .acc(acc)
    );

    // page operations also respect the busy section
    assign store_ok_raw = acc.store_ok && !(busy_q && core_store_tgt_rww);
    assign load_permit = acc.load_ok && !(busy_q && core_load_tgt_rww);
    assign irq_mask = acc.irq_block;

    // buffer load, lock set and re-enable touch no flash section, so the
    // section locks do not apply to them; they only need boot code
    assign cmd_page = cmd_is_page(cmd_q);
    assign store_permit = arm_open && !running_q
                        && (cmd_page ? store_ok_raw : core_exec_boot);

    ////////////////////////////////////////////////////////////////////////////
    // lock bits and fuse
    // capture happens on the first edge after release; the reset value is the erased state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
        end
    end

    // chip erase wins over any programming in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lock_q <= blp_pkg::LOCK_ERASED;
        end else if (!loaded_q) begin
            lock_q <= {cfg_boot_lock, cfg_app_lock};
        end else if (prog_chip_erase) begin
            lock_q <= blp_pkg::LOCK_ERASED;
        end else begin
            // programming only ever clears bits; zero is programmed
            lock_q <= lock_q
                    & (prog_lock_wr ? prog_lock_data : blp_pkg::LOCK_ERASED)
                    & (start_lock ? core_store_data[3:0] : blp_pkg::LOCK_ERASED);
        end
    end

    // no core-side write path reaches the fuse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fuse_q <= 1'b1;
        end else if (!loaded_q) begin
            fuse_q <= cfg_boot_reset_fuse;
        end
    end

    // registered, so the vector follows the captured fuse one edge later
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reset_vector <= blp_pkg::APP_RESET_ADDR;
        end else begin
            reset_vector <= fuse_q ? blp_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register and arming
    // only index 0 is writable; the status index ignores writes
    assign ctrl_wr = reg_wr && (reg_addr == blp_pkg::REG_CTRL_OFFSET);
    // commands are ignored while a page operation holds store-enable high
    assign cmd_ok = ctrl_wr && cmd_legal(reg_wdata[4:0]) && !running_q;
    assign store_take = core_store && arm_open && !running_q;

    // a fresh legal command restarts the window even if one is open
    blp_arm_timer u_timer (
        .clock(clock),
        .arst_n(arst_n),
        .start(cmd_ok),
        .consume(store_take),
        .open(arm_open),
        .expire(arm_expire)
    );

    assign start_prog = store_take && store_ok_raw && cmd_page;
    assign start_load = store_take && (cmd_q == blp_pkg::CMD_BUF_LOAD) && core_exec_boot;
    // re-enable is a store like any other, so it also needs boot code
    assign start_reen = store_take && (cmd_q == blp_pkg::CMD_REENABLE) && core_exec_boot;
    assign start_lock = store_take && (cmd_q == blp_pkg::CMD_LOCK_SET) && core_exec_boot;

    // enable follows every control write, legal command or not
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_en_q <= blp_pkg::CTRL_RESET[blp_pkg::CTRL_IRQ_EN_BIT];
        end else if (ctrl_wr) begin
            irq_en_q <= reg_wdata[blp_pkg::CTRL_IRQ_EN_BIT];
        end
    end

    // a new legal write beats every clearing cause
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_q <= blp_pkg::CTRL_RESET[4:0];
        end else if (cmd_ok) begin
            cmd_q <= reg_wdata[4:0];
        end else if (running_q && flash_done) begin
            cmd_q <= 5'h00;
        end else if (store_take && !start_prog) begin
            cmd_q <= 5'h00;
        end else if (arm_expire && !running_q) begin
            cmd_q <= 5'h00;
        end
    end

    // store-enable stays high through a page erase or write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            running_q <= 1'b0;
        end else if (start_prog) begin
            running_q <= 1'b1;
        end else if (flash_done) begin
            running_q <= 1'b0;
        end
    end

    // set and clear come from different commands, so they never collide
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else if (start_prog && core_store_tgt_rww) begin
            busy_q <= 1'b1;
        end else if (start_reen || start_load) begin
            busy_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash operation strobes, one cycle each
    // registered so each strobe is exactly one cycle wide and glitch free
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            op_erase_q <= 1'b0;
            op_write_q <= 1'b0;
            op_load_q <= 1'b0;
            op_lock_q <= 1'b0;
            op_reen_q <= 1'b0;
        end else begin
            op_erase_q <= start_prog && (cmd_q == blp_pkg::CMD_PAGE_ERASE);
            op_write_q <= start_prog && (cmd_q == blp_pkg::CMD_PAGE_WRITE);
            op_load_q <= start_load;
            op_lock_q <= start_lock;
            op_reen_q <= start_reen;
        end
    end

    assign op_page_erase = op_erase_q;
    assign op_page_write = op_write_q;
    assign op_buffer_load = op_load_q;
    assign op_lock_set = op_lock_q;
    assign op_reenable = op_reen_q;

    // no edge detect: the core samples the level like any other source
    // level request; cleared store-enable means ready
    assign store_ready_irq = irq_en_q && core_global_irq_en
                           && !cmd_q[blp_pkg::CTRL_STORE_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // read port
    // register views, assembled once for the read mux
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[blp_pkg::CTRL_IRQ_EN_BIT] = irq_en_q;
        ctrl_view[blp_pkg::CTRL_BUSY_BIT] = busy_q;
        ctrl_view[blp_pkg::CTRL_RSVD_BIT] = 1'b0;
        ctrl_view[4:0] = cmd_q;

        lock_view = 8'h00;
        lock_view[blp_pkg::LOCK_FUSE_BIT] = fuse_q;
        lock_view[3:0] = lock_q;
    end

    // zero outside the answer cycle so a stale value never reads as fresh
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                blp_pkg::REG_CTRL_OFFSET: reg_rdata_q <= ctrl_view;
                blp_pkg::REG_LOCK_OFFSET: reg_rdata_q <= lock_view;
                default: reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_q;
endmodule : blp_boot_lock

// File: hdl/blp_lock_decode.sv
// lock-bit pair decoder: store/load permits and interrupt masking
`timescale 1ns/1ps
module blp_lock_decode (
    // access request and results
    blp_access_if.dec acc
);
    logic app_no_write;
    logic app_no_read;
    logic boot_no_write;
    logic boot_no_read;

    // modes 2 and 3 forbid stores, modes 3 and 4 (high bit programmed) forbid cross loads
    assign app_no_write = (acc.app_lock[0] == 1'b0);
    assign app_no_read = !acc.app_lock[1];
    assign boot_no_write = (acc.boot_lock[0] == 1'b0);
    assign boot_no_read = !acc.boot_lock[1];

    // stores only from boot code; chip lock modes have no term here
    assign acc.store_ok = acc.exec_boot
                          && !(acc.store_tgt_boot ? boot_no_write : app_no_write);

    always_comb begin
        acc.load_ok = 1'b1;
        if (acc.exec_boot && !acc.load_tgt_boot) begin
            acc.load_ok = !app_no_read;
        end else if (!acc.exec_boot && acc.load_tgt_boot) begin
            acc.load_ok = !boot_no_read;
        end
    end

    assign acc.irq_block = (acc.vec_boot && !acc.exec_boot && app_no_read)
                         || (!acc.vec_boot && acc.exec_boot && boot_no_read);
endmodule : blp_lock_decode

// File: hdl/blp_pkg.sv
// constants for the boot lock protection block
package blp_pkg;
    // register indices on the plain register port
    localparam logic [3:0] REG_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] REG_LOCK_OFFSET = 4'h1;
    // control/status field positions
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_BUSY_BIT = 6;
    localparam int CTRL_RSVD_BIT = 5;
    localparam int CTRL_REEN_BIT = 4;
    localparam int CTRL_LOCKSET_BIT = 3;
    localparam int CTRL_PGWRT_BIT = 2;
    localparam int CTRL_PGERS_BIT = 1;
    localparam int CTRL_STORE_EN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // accepted low-five-bit command patterns
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    localparam logic [4:0] CMD_LOCK_SET = 5'h09;
    localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
    localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
    localparam logic [4:0] CMD_BUF_LOAD = 5'h01;
    // lock data positions inside the store data byte and lock status register
    localparam int LOCK_APP_LO_BIT = 0;
    localparam int LOCK_BOOT_LO_BIT = 2;
    localparam int LOCK_FUSE_BIT = 4;
    // erased (unprogrammed) value of the four lock bits
    localparam logic [3:0] LOCK_ERASED = 4'hF;
    localparam logic [1:0] LOCK_PAIR_OPEN = 2'h3;
    // store-enable arming window in clock cycles
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
endpackage : blp_pkg

// File: verif/blp_boot_lock_checker.sv
// port assertions for the boot lock protection block
`timescale 1ns/1ps
module blp_boot_lock_checker #(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'hF000
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // static configuration
    input wire logic [1:0] cfg_app_lock,
    input wire logic [1:0] cfg_boot_lock,
    input wire logic cfg_boot_reset_fuse,
    input wire logic cfg_vectors_in_boot,
    // core side
    input wire logic core_exec_boot,
    input wire logic core_store,
    input wire logic core_store_tgt_boot,
    input wire logic core_load_tgt_boot,
    input wire logic core_global_irq_en,
    input wire logic store_permit,
    input wire logic load_permit,
    input wire logic irq_mask,
    input wire logic store_ready_irq,
    input wire logic [15:0] reset_vector,
    // flash controller
    input wire logic op_page_erase,
    input wire logic op_page_write,
    input wire logic op_buffer_load,
    input wire logic op_lock_set,
    input wire logic op_reenable
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    logic [4:0] ops;
    assign ops = {op_page_erase, op_page_write, op_buffer_load, op_lock_set, op_reenable};
    ////////////////////////////////////////
    // locks and fuse are captured at the first edge, so the lock checks skip it
    boot_vector_a: assert property ($past(arst_n, 2) |-> reset_vector ==
        (cfg_boot_reset_fuse ? 16'h0000 : BOOT_RESET_ADDR)) else $error("reset vector wrong");
    irq_gate_a: assert property (!core_global_irq_en |-> !store_ready_irq)
        else $error("store ready irq without global enable");
    op_cause_a: assert property (|ops |-> $past(core_store) && $past(core_exec_boot))
        else $error("operation without boot store");
    op_pulse_a: assert property (|ops |-> $onehot(ops) ##1 ops == 5'h00)
        else $error("operation pulse malformed");
    store_denied_a: assert property (core_store && !store_permit |=> ops == 5'h00)
        else $error("denied store started operation");
    store_taken_a: assert property (core_store && store_permit |=> $onehot(ops))
        else $error("permitted store lost");
    write_lock_a: assert property (op_page_erase || op_page_write |->
        ($past(core_store_tgt_boot) ? cfg_boot_lock[0] : cfg_app_lock[0]))
        else $error("write into locked section");
    app_read_a: assert property ($past(arst_n) && core_exec_boot
        && !core_load_tgt_boot && !cfg_app_lock[1] |-> !load_permit)
        else $error("boot code read locked app");
    boot_read_a: assert property ($past(arst_n) && !core_exec_boot
        && core_load_tgt_boot && !cfg_boot_lock[1] |-> !load_permit)
        else $error("app code read locked boot");
    app_irq_a: assert property ($past(arst_n) && !core_exec_boot && cfg_vectors_in_boot
        && !cfg_app_lock[1] |-> irq_mask) else $error("irq not masked in app code");
    boot_irq_a: assert property ($past(arst_n) && core_exec_boot && !cfg_vectors_in_boot
        && !cfg_boot_lock[1] |-> irq_mask) else $error("irq not masked in boot code");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    cover property (op_reenable);
    cover property (op_lock_set);
    cover property (core_store && !store_permit);
endmodule : blp_boot_lock_checker
bind blp_boot_lock blp_boot_lock_checker #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) u_checker (
    .clock, .arst_n, .reg_rd, .reg_rdata, .cfg_app_lock, .cfg_boot_lock, .cfg_boot_reset_fuse,
    .cfg_vectors_in_boot, .core_exec_boot, .core_store, .core_store_tgt_boot, .core_load_tgt_boot,
    .core_global_irq_en, .store_permit, .load_permit, .irq_mask, .store_ready_irq, .reset_vector,
    .op_page_erase, .op_page_write, .op_buffer_load, .op_lock_set, .op_reenable);

// File: verif/blp_boot_lock_test.sv
// self-checking bench for the boot lock protection block
`timescale 1ns/1ps
module blp_boot_lock_test;
    localparam logic [15:0] BOOT_ADDR = 16'hE000;
    logic clock, arst_n, reg_wr, reg_rd, cfg_boot_reset_fuse, cfg_vectors_in_boot;
    logic prog_lock_wr, prog_chip_erase, core_exec_boot, core_store, core_store_tgt_boot;
    logic core_store_tgt_rww, core_load, core_load_tgt_boot, core_load_tgt_rww;
    logic core_global_irq_en, store_permit, load_permit, irq_mask, store_ready_irq, flash_done;
    logic op_page_erase, op_page_write, op_buffer_load, op_lock_set, op_reenable;
    logic [1:0] cfg_app_lock, cfg_boot_lock, lk;
    logic [3:0] reg_addr, prog_lock_data;
    logic [7:0] reg_wdata, reg_rdata, core_store_data, v;
    logic [15:0] reset_vector;
    int mismatches = 0;
    int n_tests = 0;
    blp_boot_lock #(.BOOT_RESET_ADDR(BOOT_ADDR)) i_dut (.clock, .arst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .cfg_app_lock, .cfg_boot_lock, .cfg_boot_reset_fuse,
        .cfg_vectors_in_boot, .prog_lock_wr, .prog_lock_data, .prog_chip_erase, .core_exec_boot,
        .core_store, .core_store_tgt_boot, .core_store_tgt_rww, .core_store_data, .core_load,
        .core_load_tgt_boot, .core_load_tgt_rww, .core_global_irq_en, .store_permit, .load_permit,
        .irq_mask, .store_ready_irq, .reset_vector, .flash_done, .op_page_erase, .op_page_write,
        .op_buffer_load, .op_lock_set, .op_reenable);
    blp_core_model i_core (.clock, .core_store, .core_store_tgt_boot, .core_store_tgt_rww,
        .core_store_data);
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic flash_pulse;
        @(posedge clock);
        flash_done <= 1'b1;
        @(posedge clock);
        flash_done <= 1'b0;
    endtask : flash_pulse
    // locks are only captured at reset, so each lock mode needs its own reset
    task automatic reset_dut(input logic [1:0] l, input logic f);
        arst_n <= 1'b0;
        cfg_app_lock <= l;
        cfg_boot_lock <= l;
        cfg_boot_reset_fuse <= f;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : reset_dut
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
    initial begin
        {arst_n, reg_wr, reg_rd, prog_lock_wr, prog_chip_erase, core_exec_boot} = '0;
        {core_load, core_load_tgt_boot, core_load_tgt_rww, core_global_irq_en} = '0;
        {flash_done, cfg_vectors_in_boot, cfg_boot_reset_fuse, cfg_app_lock, cfg_boot_lock} = '0;
        {reg_addr, prog_lock_data, reg_wdata, lk} = '0;
        for (int i = 0; i < 4; i++) begin
            lk = i[1:0];
            reset_dut(lk, lk[0]);
            rd(4'h1);
            chk("lock status", v, {3'h0, lk[0], lk, lk});
            rd(4'h0);
            chk("control reset", v, 8'h00);
            chk("reset vector", reset_vector, lk[0] ? 16'h0000 : BOOT_ADDR);
            core_exec_boot <= 1'b1;
            core_load_tgt_boot <= 1'b0;
            cfg_vectors_in_boot <= 1'b0;
            @(posedge clock);
            #1 chk("boot reads app", load_permit, lk[1]);
            chk("boot irq mask", irq_mask, !lk[1]);
            core_exec_boot <= 1'b0;
            core_load_tgt_boot <= 1'b1;
            cfg_vectors_in_boot <= 1'b1;
            @(posedge clock);
            #1 chk("app reads boot", load_permit, lk[1]);
            chk("app irq mask", irq_mask, !lk[1]);
            core_exec_boot <= 1'b1;
            wr(4'h0, 8'h05);
            i_core.store(0, 1'b0, 1'b0, 8'h00);
            #1 chk("app page write", op_page_write, lk[0]);
            flash_pulse();
            wr(4'h0, 8'h03);
            i_core.store(0, 1'b1, 1'b0, 8'h00);
            #1 chk("boot page erase", op_page_erase, lk[0]);
            flash_pulse();
        end
        reset_dut(2'h3, 1'b1);
        wr(4'h0, 8'hFF);
        rd(4'h0);
        chk("unlisted command", v, 8'h80);
        core_global_irq_en <= 1'b1;
        @(posedge clock);
        #1 chk("store ready irq", store_ready_irq, 1'b1);
        wr(4'h0, 8'h81);
        #1 chk("irq while armed", store_ready_irq, 1'b0);
        repeat (5) @(posedge clock);
        #1 chk("irq after expiry", store_ready_irq, 1'b1);
        core_global_irq_en <= 1'b0;
        @(posedge clock);
        #1 chk("irq gated", store_ready_irq, 1'b0);
        wr(4'h1, 8'h00);
        rd(4'h1);
        chk("lock reg read only", v, 8'h1F);
        rd(4'h7);
        chk("unmapped read", v, 8'h00);
        wr(4'h0, 8'h01);
        i_core.store(3, 1'b0, 1'b0, 8'h00);
        #1 chk("late store", op_buffer_load, 1'b1);
        wr(4'h0, 8'h01);
        i_core.store(4, 1'b0, 1'b0, 8'h00);
        #1 chk("expired store", op_buffer_load, 1'b0);
        rd(4'h0);
        chk("enable cleared", v, 8'h00);
        wr(4'h0, 8'h03);
        i_core.store(0, 1'b0, 1'b1, 8'h00);
        #1 chk("rww erase", op_page_erase, 1'b1);
        core_load_tgt_boot <= 1'b0;
        core_load_tgt_rww <= 1'b1;
        rd(4'h0);
        chk("busy set", v[6], 1'b1);
        chk("rww load denied", load_permit, 1'b0);
        wr(4'h0, 8'h11);
        i_core.store(0, 1'b0, 1'b0, 8'h00);
        #1 chk("reenable while busy", op_reenable, 1'b0);
        flash_pulse();
        wr(4'h0, 8'h05);
        i_core.store(0, 1'b0, 1'b1, 8'h00);
        #1 chk("rww write while busy", op_page_write, 1'b0);
        wr(4'h0, 8'h11);
        i_core.store(0, 1'b0, 1'b0, 8'h00);
        #1 chk("reenable", op_reenable, 1'b1);
        rd(4'h0);
        chk("busy cleared", v[6], 1'b0);
        chk("rww load allowed", load_permit, 1'b1);
        wr(4'h0, 8'h03);
        i_core.store(0, 1'b0, 1'b1, 8'h00);
        flash_pulse();
        wr(4'h0, 8'h01);
        i_core.store(0, 1'b0, 1'b0, 8'h00);
        #1 chk("buffer load", op_buffer_load, 1'b1);
        rd(4'h0);
        chk("busy cleared by load", v[6], 1'b0);
        wr(4'h0, 8'h09);
        i_core.store(0, 1'b1, 1'b0, 8'h0A);
        #1 chk("lock set", op_lock_set, 1'b1);
        wr(4'h0, 8'h09);
        i_core.store(0, 1'b1, 1'b0, 8'hEF);
        rd(4'h1);
        chk("locks kept", v, 8'h1A);
        prog_lock_data <= 4'h7;
        prog_lock_wr <= 1'b1;
        @(posedge clock);
        prog_lock_wr <= 1'b0;
        rd(4'h1);
        chk("programmer lock", v, 8'h12);
        prog_chip_erase <= 1'b1;
        @(posedge clock);
        prog_chip_erase <= 1'b0;
        rd(4'h1);
        chk("chip erase", v, 8'h1F);
        end_of_test();
    end
endmodule : blp_boot_lock_test

// File: verif/blp_core_model.sv
// processor core model issuing program-store instructions
`timescale 1ns/1ps
module blp_core_model (
    // clock
    input wire logic clock,
    // store instruction
    output logic core_store,
    output logic core_store_tgt_boot,
    output logic core_store_tgt_rww,
    output logic [7:0] core_store_data
);
    initial begin
        core_store = 1'b0;
        core_store_tgt_boot = 1'b0;
        core_store_tgt_rww = 1'b0;
        core_store_data = 8'h00;
    end
    // n is the delay after the control write; up to 3 stays inside the window
    task automatic store(input int n, input logic b, r, input logic [7:0] d);
        repeat (n) @(posedge clock);
        core_store <= 1'b1;
        core_store_tgt_boot <= b;
        core_store_tgt_rww <= r;
        core_store_data <= d;
        @(posedge clock);
        core_store <= 1'b0;
        // released qualifiers turn over so a stale value cannot pass for a live one
        core_store_tgt_boot <= ~b;
        core_store_tgt_rww <= ~r;
        core_store_data <= ~d;
    endtask : store
endmodule : blp_core_model
